// ---- logic/zcd_defs.vh ----
`ifndef ZCD_DEFS_VH
`define ZCD_DEFS_VH
// ==========================================================
// register map (byte addresses, one word each)
`define ZCD_ADDR_CONTROL 12'h000
`define ZCD_ADDR_FLAG 12'h004
`define ZCD_ADDR_UNMASK 12'h008
`define ZCD_ADDR_WIDTH 12
// ==========================================================
// control register fields
`define ZCD_BIT_SWITCH_ON 7
`define ZCD_BIT_LOGIC 5
`define ZCD_BIT_INVERT 4
`define ZCD_BIT_RISE_ARM 1
`define ZCD_BIT_FALL_ARM 0
// flag / unmask register fields
`define ZCD_BIT_FLAG 0
// ==========================================================
// reset values
`define ZCD_RST_INVERT 1'b0
`define ZCD_RST_ARM 1'b0
`define ZCD_RST_UNMASK 1'b0
`define ZCD_RST_FLAG 1'b0
`define ZCD_SYNC_STAGES 2
`endif

// ---- logic/zcd_edge.v ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// rising and falling edge detectors on the logic level
module zcd_edge (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire level_in,
   output wire rise_pulse,
   output wire fall_pulse
);
   reg prev_reg;
   reg primed_reg;

   // previous level; primed avoids a spurious edge after reset
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_reg <= 1'b0;
         primed_reg <= 1'b0;
      end else if (clk_en) begin
         prev_reg <= level_in;
         primed_reg <= 1'b1;
      end
   end

   assign rise_pulse = clk_en & primed_reg & level_in & ~prev_reg;
   assign fall_pulse = clk_en & primed_reg & ~level_in & prev_reg;
endmodule
`default_nettype wire

// ---- logic/zcd_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop synchroniser for the raw comparator level
module zcd_sync (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire async_in,
   output wire sync_out
);
   reg meta_reg;
   reg sync_reg;

   // first stage feeds only the second stage
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else if (clk_en) begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ---- logic/zcd_top.v ----
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "zcd_defs.vh"
// Function
// [RQ1] logic level is raw sink indication, inverted when invert is set
// [RQ2] invert set: level high while sourcing, low while sinking
// [RQ3] invert clear: level high while sinking, low while sourcing
// [RQ4] inversion acts even while the detector is switched off
// [RQ5] separate rising and falling edge detectors watch the logic level
// [RQ6] flag set by a detector edge only when its arm bit is set
// [RQ7] control bit 1 arms rising edges, bit 0 arms falling edges
// [RQ8] software needs unmask, peripheral and global gates plus an arm
// [RQ9] an invert change is a level change and may set the flag
// [RQ10] only software clears the flag; hardware never clears it
// [RQ11] armed edge in the clearing cycle wins; flag stays set
// [RQ12] detection, flag and drive keep running in sleep
// [RQ13] default-off config clear: switch-on bit resets to one
// [RQ14] default-off config set: software must write switch-on
// [RQ15] control bit 7 set enables detection and forces pin drive
// [RQ16] control bit 7 clear returns pin to normal pin controls
// [RQ17] logic level read at control bit 5, read only
// [RQ18] invert is read/write bit 4, reset zero
// [RQ19] control bits 6, 3, 2 read zero and ignore writes
// [RQ20] raw comparator input passes a two-flop synchroniser
module zcd_top (
   input wire clk_sys,
   input wire rst_b,
   input wire clk_en,
   input wire zc_default_off_cfg,
   input wire sleep_mode,
   input wire raw_sink_active,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg detector_switch_on,
   output reg zc_logic_signal,
   output reg zc_irq_flag,
   output reg zc_irq_unmask,
   output wire zc_irq_request
);
   // ==========================================================
   // control state
   reg output_invert;
   reg rise_irq_arm;
   reg fall_irq_arm;
   reg cfg_taken_reg;
   wire raw_sync;
   wire rise_pulse;
   wire fall_pulse;
   wire level_next;
   wire apb_access;
   wire wr_en;
   wire sel_ctrl;
   wire sel_flag;
   wire sel_unmask;
   wire addr_ok;
   wire flag_set;
   wire flag_clr;
   wire [7:0] ctrl_read;

   // ==========================================================
   // synchroniser and edge detectors
   zcd_sync u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .async_in(raw_sink_active),
      .sync_out(raw_sync)
   ); // RQ20

   // polarity applied whatever the switch-on bit says
   assign level_next = raw_sync ^ output_invert; // RQ1 RQ2 RQ3 RQ4 RQ9

   // level register; sleep has no effect on it
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         zc_logic_signal <= 1'b0;
      end else if (clk_en) begin
         zc_logic_signal <= level_next; // RQ12
      end
   end

   zcd_edge u_edge (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .level_in(zc_logic_signal),
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse)
   ); // RQ5

   // ==========================================================
   // apb slave decode, zero wait states
   assign apb_access = psel & penable & clk_en;
   assign wr_en = apb_access & pwrite & pstrb[0];
   assign sel_ctrl = (paddr == `ZCD_ADDR_CONTROL);
   assign sel_flag = (paddr == `ZCD_ADDR_FLAG);
   assign sel_unmask = (paddr == `ZCD_ADDR_UNMASK);
   assign addr_ok = sel_ctrl | sel_flag | sel_unmask;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // control read image, unimplemented bits zero
   assign ctrl_read = {detector_switch_on, 1'b0, zc_logic_signal,
      output_invert, 2'b00, rise_irq_arm, fall_irq_arm}; // RQ17 RQ19

   // ==========================================================
   // control and unmask register writes
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         output_invert <= `ZCD_RST_INVERT; // RQ18
         rise_irq_arm <= `ZCD_RST_ARM;
         fall_irq_arm <= `ZCD_RST_ARM;
         zc_irq_unmask <= `ZCD_RST_UNMASK;
      end else if (wr_en) begin
         if (sel_ctrl) begin
            output_invert <= pwdata[`ZCD_BIT_INVERT]; // RQ18
            rise_irq_arm <= pwdata[`ZCD_BIT_RISE_ARM]; // RQ7
            fall_irq_arm <= pwdata[`ZCD_BIT_FALL_ARM]; // RQ7
         end
         if (sel_unmask) begin
            zc_irq_unmask <= pwdata[`ZCD_BIT_FLAG];
         end
      end
   end

   // switch-on bit: reset value comes from the config strap
   // sampled on the first enabled clock after reset release
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         detector_switch_on <= 1'b0;
         cfg_taken_reg <= 1'b0;
      end else if (clk_en) begin
         cfg_taken_reg <= 1'b1;
         if (!cfg_taken_reg) begin
            detector_switch_on <= ~zc_default_off_cfg; // RQ13 RQ14
         end else if (wr_en && sel_ctrl) begin
            detector_switch_on <= pwdata[`ZCD_BIT_SWITCH_ON]; // RQ15 RQ16
         end
      end
   end

   // ==========================================================
   // interrupt flag: set wins over software clear
   assign flag_set = (rise_pulse & rise_irq_arm) |
      (fall_pulse & fall_irq_arm); // RQ6 RQ7
   assign flag_clr = wr_en & sel_flag & ~pwdata[`ZCD_BIT_FLAG];

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         zc_irq_flag <= `ZCD_RST_FLAG;
      end else if (clk_en) begin
         if (flag_set) begin
            zc_irq_flag <= 1'b1; // RQ11 RQ12
         end else if (flag_clr) begin
            zc_irq_flag <= 1'b0; // RQ10
         end
      end
   end

   // request to the core's gates; they live outside
   assign zc_irq_request = zc_irq_flag & zc_irq_unmask; // RQ8

   // ==========================================================
   // read data register
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         if (sel_ctrl) begin
            prdata <= {24'h000000, ctrl_read};
         end else if (sel_flag) begin
            prdata <= {31'h00000000, zc_irq_flag};
         end else if (sel_unmask) begin
            prdata <= {31'h00000000, zc_irq_unmask};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // sleep leaves everything running; input kept for the port map
   wire unused_sleep = sleep_mode;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// bench for the zero-cross block
module testbench;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic cfg = 1'b0;
   logic slp = 1'b0;
   logic sink = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdv;
   logic raw, pready, son, irq;
   logic perr, errv;
   int num_errors = 0;
   int checked = 0;
   zcd_top zcd_top_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
      .zc_default_off_cfg(cfg), .sleep_mode(slp),
      .raw_sink_active(raw), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(perr),
      .detector_switch_on(son), .zc_logic_signal(),
      .zc_irq_flag(), .zc_irq_unmask(), .zc_irq_request(irq)
   );
   zcd_comp_model zcd_comp_model_inst (
      .sink_cmd(sink), .raw_sink_active(raw)
   );
   // clock
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // one apb transfer after a settling gap
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      repeat (8) @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   task automatic rst(input logic c);
      rst_b <= 1'b0;
      cfg <= c;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
   endtask
   task automatic final_report;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // test sequence
   initial begin
      rst(1'b0);
      rc(12'h000, 32'h80);
      bus(1'b1, 12'h000, 32'hff);
      rc(12'h000, 32'hb3);
      rc(12'h004, 32'h1);
      bus(1'b1, 12'h004, 32'h0);
      bus(1'b1, 12'h008, 32'h1);
      rc(12'h004, 32'h0);
      sink <= 1'b1;
      rc(12'h000, 32'h93);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 12'h004, 32'h0);
      bus(1'b1, 12'h000, 32'h80);
      rc(12'h000, 32'ha0);
      rc(12'h004, 32'h0);
      bus(1'b1, 12'h000, 32'h10);
      // switch-on updates on the access edge; look one edge later
      @(posedge clk_sys);
      chk({31'h0, son}, 32'h0);
      rc(12'h000, 32'h10);
      slp <= 1'b1;
      bus(1'b1, 12'h000, 32'h82);
      @(posedge clk_sys);
      chk({31'h0, son}, 32'h1);
      rc(12'h004, 32'h1);
      rc(12'h00c, 32'h0);
      chk({31'h0, errv}, 32'h1);
      bus(1'b1, 12'h000, 32'h83);
      // falling edge pulse lands on the access edge of the clear
      fork
         bus(1'b1, 12'h004, 32'h0);
         begin
            repeat (6) @(posedge clk_sys);
            sink <= 1'b0;
         end
      join
      rc(12'h004, 32'h1);
      sink <= 1'b0;
      rst(1'b1);
      rc(12'h000, 32'h0);
      bus(1'b1, 12'h000, 32'h80);
      rc(12'h000, 32'h80);
      final_report;
   end
   // watchdog
   initial begin
      repeat (2000) @(posedge clk_sys);
      num_errors++;
      final_report;
   end
endmodule
`default_nettype wire

// ---- test/zcd_comp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// comparator: reports which current the pin drive applies
module zcd_comp_model (
   input wire logic sink_cmd,
   output logic raw_sink_active
);
   // indication follows the applied current
   assign raw_sink_active = sink_cmd;
endmodule
`default_nettype wire

// ---- test/zcd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker for the zero-cross block
module zcd_props (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic zc_default_off_cfg,
   input wire logic raw_sink_active,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic detector_switch_on,
   input wire logic zc_logic_signal,
   input wire logic zc_irq_flag,
   input wire logic zc_irq_unmask,
   input wire logic zc_irq_request
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   logic acc;
   logic wc;
   logic rc;
   // access phase, control write, control read
   assign acc = psel & penable;
   assign wc = acc & pwrite & pstrb[0] & (paddr == 12'h000);
   assign rc = acc & !pwrite & (paddr == 12'h000);
   sw_reset_a: assert property ($rose(rst_b) |=>
      detector_switch_on == !$past(zc_default_off_cfg))
      else $error("switch-on not loaded from strap");
   lvl_cause_a: assert property ($changed(zc_logic_signal) |->
      $past(raw_sink_active, 3) != $past(raw_sink_active, 4)
      || $past(wc) || $past(wc, 2)) else $error("level moved alone");
   flag_cause_a: assert property ($rose(zc_irq_flag) |->
      $past(zc_logic_signal) != $past(zc_logic_signal, 4))
      else $error("flag set without edge");
   sticky_flag_a: assert property ($fell(zc_irq_flag) |->
      $past(acc & pwrite & pstrb[0] & paddr == 12'h004 & !pwdata[0]))
      else $error("flag cleared by hardware");
   irq_gate_a: assert property (
      zc_irq_request == (zc_irq_flag & zc_irq_unmask))
      else $error("request not flag and unmask");
   ro_bits_a: assert property (rc |-> prdata[31:8] == 0
      && prdata[6] == 0 && prdata[3:2] == 0) else $error("bits not 0");
   rd_ctl_a: assert property (rc |->
      prdata[5] == $past(zc_logic_signal)
      && prdata[7] == $past(detector_switch_on)) else $error("bad read");
   flag_rd_a: assert property (acc && !pwrite && paddr == 12'h004 |->
      prdata == {31'h0, $past(zc_irq_flag)}) else $error("bad flag read");
   c_rise: cover property ($rose(zc_irq_flag));
   c_fall: cover property ($fell(zc_irq_flag));
   c_err: cover property (acc && pslverr);
endmodule
bind zcd_top zcd_props zcd_props_inst (.*);
`default_nettype wire
